/* File: logic/tcsr_pkg.sv */
// Purpose: Constants for the trigger, sample clock and sync router
// Assumes: 32-bit register port, byte addresses, one word per register
// Notes:   Line selector codes 0..7 pick a bus line, 8 and up mean no line
`default_nettype none
package tcsr_pkg;
    // Trigger bus geometry and selectors
    localparam int         LINES    = 8;
    localparam int         SEL_W    = 4;
    localparam int         LIDX_W   = 3;
    localparam logic [3:0] SEL_NONE = 4'h8;
    localparam int         ADDR_W   = 8;
    // Register offsets
    localparam logic [7:0] A_DIR    = 8'h00;
    localparam logic [7:0] A_SCOPE  = 8'h04;
    localparam logic [7:0] A_CLK    = 8'h08;
    localparam logic [7:0] A_SYNC   = 8'h0c;
    localparam logic [7:0] A_TRIG   = 8'h10;
    localparam logic [7:0] A_PLXI   = 8'h14;
    localparam logic [7:0] A_PDIO   = 8'h18;
    localparam logic [7:0] A_PMISC  = 8'h1c;
    localparam logic [7:0] A_CMD    = 8'h20;
    localparam logic [7:0] A_LIMR   = 8'h24;
    localparam logic [7:0] A_LIMS   = 8'h28;
    localparam logic [7:0] A_STAT   = 8'h2c;
    // Field positions
    localparam int ROLE_B   = 0;
    localparam int OSEL_LSB = 4;
    localparam int ISEL_LSB = 8;
    localparam int SRC_LSB  = 0;
    localparam int FALL_B   = 2;
    localparam int EDGE_LSB = 4;
    localparam int POUT_LSB = 8;
    localparam int PIN_LSB  = 12;
    localparam int PVAL_LSB = 8;
    localparam int TMR_B    = 0;
    localparam int SWEN_B   = 1;
    localparam int SYNC_B   = 0;
    localparam int SWTRG_B  = 1;
    localparam int START_B  = 2;
    localparam int ABORT_B  = 3;
    localparam int MIN_B    = 0;
    localparam int MAX_B    = 1;
    localparam int WAIT_B   = 0;
    localparam int ACQ_B    = 1;
    localparam int ADCK_B   = 2;
    // Reset values
    localparam logic [7:0] DIR_RST   = 8'h00;
    localparam logic [7:0] SCOPE_RST = 8'hff;
    // Trigger source codes
    localparam logic [1:0] SRC_IMM  = 2'h0;
    localparam logic [1:0] SRC_EDGE = 2'h1;
    localparam logic [1:0] SRC_PAT  = 2'h2;
    // Pulse timing
    localparam int CLK_NS    = 100;
    localparam int PULSE_NS  = 500;
    localparam int PULSE_CYC = (PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W     = 4;
    // Trigger layer states
    typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_ACQ} tcsr_state_t;
endpackage
`default_nettype wire

/* File: logic/tcsr_top.sv */
// Purpose: Sample clock, ADC sync and trigger routing over an 8-line bus
// Assumes: Bus lines, oscillator and digital inputs are asynchronous pins
// Notes:   Bus lines are sampled by i_clk; outputs come from flops, o_trig_bus_oe and o_acquiring through a gate on flops
// Operation
// [RULE1] Clock master clocks ADC from own oscillator.
// [RULE2] Internal clock line never reaches the bus.
// [RULE3] Clock may leave on one line, return on another.
// [RULE4] Output selector picks clock line; none means internal.
// [RULE5] Input selector picks ADC clock line; none means internal.
// [RULE6] Standalone: both clock selectors at none.
// [RULE7] Clock lines set up before clock source.
// [RULE8] Clock output line is an output, scope as needed.
// [RULE9] Clock return line is a full-scope input.
// [RULE10] Clock slave clocks ADC from selected line.
// [RULE11] Sync master pulses per soft sync command.
// [RULE12] Sync output is a bus line or internal line.
// [RULE13] ADC sync comes from a selectable line.
// [RULE14] Sync lines set up before use.
// [RULE15] Sync slave takes sync from input line.
// [RULE16] Immediate source skips trigger wait.
// [RULE17] Edge source fires on chosen line edge.
// [RULE18] Pattern combines lines, inputs, timer, soft trigger.
// [RULE19] Pattern events drive an output line.
// [RULE20] Pattern lines set up with direction and scope.
// [RULE21] Slave uses immediate or master pattern line.
// [RULE22] Limit trips flagged, drive routed lines.
`timescale 1ns/1ps
`default_nettype none
module tcsr_top
    import tcsr_pkg::*;
#(
    parameter int DIO_W = 16,
    parameter int CH    = 48
) (
    // Clock and reset
    input  wire logic              i_clk,
    input  wire logic              i_resetn,
    // Register port
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [31:0]       i_wdata,
    input  wire logic              i_wr,
    input  wire logic              i_rd,
    output logic      [31:0]       o_rdata,
    // Trigger bus pins
    input  wire logic [LINES-1:0]  i_trig_bus,
    output logic      [LINES-1:0]  o_trig_bus,
    output logic      [LINES-1:0]  o_trig_bus_oe,
    // Oscillator, digital inputs, timer
    input  wire logic              i_osc,
    input  wire logic [DIO_W-1:0]  i_dio,
    input  wire logic              i_timer_evt,
    // Limit comparators and acquisition
    input  wire logic [CH-1:0]     i_min_trip,
    input  wire logic [CH-1:0]     i_max_trip,
    input  wire logic              i_acq_done,
    // ADC side
    output logic                   o_adc_clk,
    output logic                   o_adc_sync,
    output logic                   o_trigger,
    output logic                   o_acquiring
);

    typedef struct packed {
        logic [LINES-1:0] bus_s1, bus_s2, line_prev, drv, dir, scope, lim_route;
        logic             osc_s1, osc_s2;
        logic [DIO_W-1:0] dio_s1, dio_s2;
        logic             clk_slave, sync_slave, fall, tmr_en, sw_en;
        logic [SEL_W-1:0] clk_out, clk_in, sync_out, sync_in;
        logic [SEL_W-1:0] edge_line, pat_out, pat_in;
        logic [1:0]       src;
        logic [LINES-1:0] pat_lmask, pat_lval;
        logic [DIO_W-1:0] pat_dmask, pat_dval;
        logic             pat_prev, sync_prev, adc_clk, adc_sync, trig_pulse;
        logic [CNT_W-1:0] sync_cnt, pat_cnt;
        logic [1:0]       lim_flags;
        tcsr_state_t      st;
        logic [31:0]      rdata;
    } tcsr_regs_t;

    tcsr_regs_t       r_ff;
    tcsr_regs_t       nxt_r;
    logic [LINES-1:0] line_int;
    logic [LINES-1:0] drv;
    logic [31:0]      rd;
    logic             cmd_wr, sw_sync, sw_trig, sw_start, sw_abort;
    logic             int_clk, sync_gen, int_sync, sync_src;
    logic             pat_match, pat_evt, pat_any, pat_gen;
    logic             edge_now, edge_was, pin_now, pin_was, trig_evt;
    logic             any_min, any_max;

    // Bit of a line vector, or the fallback when the selector says no line
    function automatic logic pick(input logic [LINES-1:0] v, input logic [SEL_W-1:0] s,
                                  input logic alt);
        pick = (s < SEL_NONE) ? v[s[LIDX_W-1:0]] : alt;
    endfunction

    // Next-state logic
    always_comb begin
        nxt_r = r_ff;
        // Two-flop synchronisers for pins
        nxt_r.bus_s1 = i_trig_bus;
        nxt_r.bus_s2 = r_ff.bus_s1;
        nxt_r.osc_s1 = i_osc;
        nxt_r.osc_s2 = r_ff.osc_s1;
        nxt_r.dio_s1 = i_dio;
        nxt_r.dio_s2 = r_ff.dio_s1;
        // Software command strobes
        cmd_wr   = i_wr && (i_addr == A_CMD);
        sw_sync  = cmd_wr && i_wdata[SYNC_B];
        sw_trig  = cmd_wr && i_wdata[SWTRG_B];
        sw_start = cmd_wr && i_wdata[START_B];
        sw_abort = cmd_wr && i_wdata[ABORT_B];
        // Line value seen inside: own drive if output, pin if external input
        line_int = (r_ff.drv & r_ff.dir) | (r_ff.bus_s2 & ~r_ff.dir & r_ff.scope); // see [RULE8] see [RULE10]

        // Sample clock selection
        int_clk = ~r_ff.clk_slave && (r_ff.clk_out >= SEL_NONE) && r_ff.osc_s2; // see [RULE1] see [RULE4]
        nxt_r.adc_clk = pick(line_int, r_ff.clk_in, int_clk); // see [RULE3] see [RULE5] see [RULE10]

        // Sync pulse generation, master only
        if (sw_sync && !r_ff.sync_slave) begin
            nxt_r.sync_cnt = CNT_W'(PULSE_CYC); // see [RULE11] see [RULE15]
        end else if (r_ff.sync_cnt != '0) begin
            nxt_r.sync_cnt = r_ff.sync_cnt - 1'b1;
        end
        sync_gen = (r_ff.sync_cnt != '0);
        int_sync = ~r_ff.sync_slave && (r_ff.sync_out >= SEL_NONE) && sync_gen; // see [RULE12]
        sync_src = pick(line_int, r_ff.sync_in, int_sync); // see [RULE13] see [RULE15]
        nxt_r.sync_prev = sync_src;
        nxt_r.adc_sync  = sync_src && !r_ff.sync_prev;

        // Pattern combination, all enabled terms must hold
        pat_any   = (|r_ff.pat_lmask) || (|r_ff.pat_dmask) || r_ff.tmr_en || r_ff.sw_en;
        pat_match = pat_any
                  && (&((line_int ~^ r_ff.pat_lval) | ~r_ff.pat_lmask))
                  && (&((r_ff.dio_s2 ~^ r_ff.pat_dval) | ~r_ff.pat_dmask))
                  && (!r_ff.tmr_en || i_timer_evt)
                  && (!r_ff.sw_en || sw_trig); // see [RULE18]
        nxt_r.pat_prev = pat_match;
        pat_evt = pat_match && !r_ff.pat_prev && (r_ff.src == SRC_PAT) && !r_ff.clk_slave; // see [RULE21]
        if (pat_evt) begin
            nxt_r.pat_cnt = CNT_W'(PULSE_CYC);
        end else if (r_ff.pat_cnt != '0) begin
            nxt_r.pat_cnt = r_ff.pat_cnt - 1'b1;
        end
        pat_gen = (r_ff.pat_cnt != '0);

        // Limit flags, a new trip wins over a clear
        any_min = |i_min_trip;
        any_max = |i_max_trip;
        nxt_r.lim_flags = r_ff.lim_flags;
        if (i_wr && (i_addr == A_LIMS)) begin
            nxt_r.lim_flags = r_ff.lim_flags & ~i_wdata[MAX_B:MIN_B];
        end
        nxt_r.lim_flags[MIN_B] = nxt_r.lim_flags[MIN_B] | any_min; // see [RULE22]
        nxt_r.lim_flags[MAX_B] = nxt_r.lim_flags[MAX_B] | any_max;

        // Line drive: clock, sync, pattern and limit events
        for (int i = 0; i < LINES; i++) begin
            drv[i] = (~r_ff.clk_slave && (r_ff.clk_out == SEL_W'(i)) && r_ff.osc_s2) // see [RULE1] [RULE2]
                   | (~r_ff.sync_slave && (r_ff.sync_out == SEL_W'(i)) && sync_gen) // see [RULE12]
                   | ((r_ff.pat_out == SEL_W'(i)) && pat_gen) // see [RULE19]
                   | (r_ff.lim_route[i] && (any_min || any_max)); // see [RULE22]
        end
        nxt_r.drv = drv;

        // Trigger events from a bus line edge
        nxt_r.line_prev = line_int;
        edge_now = pick(line_int, r_ff.edge_line, 1'b0);
        edge_was = pick(r_ff.line_prev, r_ff.edge_line, 1'b0);
        pin_now  = pick(line_int, r_ff.pat_in, 1'b0);
        pin_was  = pick(r_ff.line_prev, r_ff.pat_in, 1'b0);
        if (r_ff.src == SRC_EDGE) begin
            trig_evt = r_ff.fall ? (edge_was && !edge_now) : (edge_now && !edge_was); // see [RULE17]
        end else if (r_ff.src == SRC_PAT) begin
            trig_evt = pin_now && !pin_was; // see [RULE19] see [RULE21]
        end else begin
            trig_evt = 1'b0;
        end

        // Trigger layer
        nxt_r.trig_pulse = 1'b0;
        unique case (r_ff.st)
            ST_IDLE: begin
                if (sw_start) begin
                    if (r_ff.src == SRC_IMM) begin
                        nxt_r.st         = ST_ACQ; // see [RULE16]
                        nxt_r.trig_pulse = 1'b1;
                    end else begin
                        nxt_r.st = ST_WAIT;
                    end
                end
            end
            ST_WAIT: begin
                if (sw_abort) begin
                    nxt_r.st = ST_IDLE;
                end else if (trig_evt) begin
                    nxt_r.st         = ST_ACQ;
                    nxt_r.trig_pulse = 1'b1;
                end
            end
            ST_ACQ: begin
                if (sw_abort || i_acq_done) begin
                    nxt_r.st = ST_IDLE;
                end
            end
            default: nxt_r.st = ST_IDLE;
        endcase

        // Register writes
        if (i_wr) begin
            unique case (i_addr)
                A_DIR:   nxt_r.dir       = i_wdata[LINES-1:0];
                A_SCOPE: nxt_r.scope     = i_wdata[LINES-1:0];
                A_LIMR:  nxt_r.lim_route = i_wdata[LINES-1:0];
                A_CLK: begin
                    nxt_r.clk_slave = i_wdata[ROLE_B];
                    nxt_r.clk_out   = i_wdata[OSEL_LSB +: SEL_W];
                    nxt_r.clk_in    = i_wdata[ISEL_LSB +: SEL_W];
                end
                A_SYNC: begin
                    nxt_r.sync_slave = i_wdata[ROLE_B];
                    nxt_r.sync_out   = i_wdata[OSEL_LSB +: SEL_W];
                    nxt_r.sync_in    = i_wdata[ISEL_LSB +: SEL_W];
                end
                A_TRIG: begin
                    nxt_r.src       = i_wdata[SRC_LSB +: 2];
                    nxt_r.fall      = i_wdata[FALL_B];
                    nxt_r.edge_line = i_wdata[EDGE_LSB +: SEL_W];
                    nxt_r.pat_out   = i_wdata[POUT_LSB +: SEL_W];
                    nxt_r.pat_in    = i_wdata[PIN_LSB +: SEL_W];
                end
                A_PLXI: begin
                    nxt_r.pat_lmask = i_wdata[LINES-1:0];
                    nxt_r.pat_lval  = i_wdata[PVAL_LSB +: LINES];
                end
                A_PDIO: begin
                    nxt_r.pat_dmask = i_wdata[DIO_W-1:0];
                    nxt_r.pat_dval  = i_wdata[DIO_W +: DIO_W];
                end
                A_PMISC: begin
                    nxt_r.tmr_en = i_wdata[TMR_B];
                    nxt_r.sw_en  = i_wdata[SWEN_B];
                end
                default: ;
            endcase
        end

        // Register reads, data one cycle later
        rd = '0;
        unique case (i_addr)
            A_DIR:   rd[LINES-1:0] = r_ff.dir;
            A_SCOPE: rd[LINES-1:0] = r_ff.scope;
            A_LIMR:  rd[LINES-1:0] = r_ff.lim_route;
            A_CLK: begin
                rd[ROLE_B] = r_ff.clk_slave;
                rd[OSEL_LSB +: SEL_W] = r_ff.clk_out;
                rd[ISEL_LSB +: SEL_W] = r_ff.clk_in;
            end
            A_SYNC: begin
                rd[ROLE_B] = r_ff.sync_slave;
                rd[OSEL_LSB +: SEL_W] = r_ff.sync_out;
                rd[ISEL_LSB +: SEL_W] = r_ff.sync_in;
            end
            A_TRIG: begin
                rd[SRC_LSB +: 2] = r_ff.src;
                rd[FALL_B] = r_ff.fall;
                rd[EDGE_LSB +: SEL_W] = r_ff.edge_line;
                rd[POUT_LSB +: SEL_W] = r_ff.pat_out;
                rd[PIN_LSB +: SEL_W] = r_ff.pat_in;
            end
            A_PLXI: begin
                rd[LINES-1:0] = r_ff.pat_lmask;
                rd[PVAL_LSB +: LINES] = r_ff.pat_lval;
            end
            A_PDIO: begin
                rd[DIO_W-1:0] = r_ff.pat_dmask;
                rd[DIO_W +: DIO_W] = r_ff.pat_dval;
            end
            A_PMISC: begin
                rd[TMR_B] = r_ff.tmr_en;
                rd[SWEN_B] = r_ff.sw_en;
            end
            A_LIMS:  rd[MAX_B:MIN_B] = r_ff.lim_flags;
            A_STAT: begin
                rd[WAIT_B] = (r_ff.st == ST_WAIT);
                rd[ACQ_B] = (r_ff.st == ST_ACQ);
                rd[ADCK_B] = r_ff.adc_clk;
            end
            default: ;
        endcase
        nxt_r.rdata = i_rd ? rd : '0;
    end

    // State register
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            r_ff          <= '0;
            r_ff.dir      <= DIR_RST;
            r_ff.scope    <= SCOPE_RST;
            r_ff.clk_out  <= SEL_NONE;
            r_ff.clk_in   <= SEL_NONE;
            r_ff.sync_out <= SEL_NONE;
            r_ff.sync_in  <= SEL_NONE;
            r_ff.edge_line <= SEL_NONE;
            r_ff.pat_out  <= SEL_NONE;
            r_ff.pat_in   <= SEL_NONE;
            r_ff.st       <= ST_IDLE;
        end else begin
            r_ff <= nxt_r;
        end
    end

    // Outputs; a pin is driven only for an output line with external scope
    assign o_rdata       = r_ff.rdata;
    assign o_trig_bus    = r_ff.drv;
    assign o_trig_bus_oe = r_ff.dir & r_ff.scope; // see [RULE8]
    assign o_adc_clk     = r_ff.adc_clk;
    assign o_adc_sync    = r_ff.adc_sync;
    assign o_trigger     = r_ff.trig_pulse;
    assign o_acquiring   = (r_ff.st == ST_ACQ);

endmodule // tcsr_top
`default_nettype wire

/* File: test/tb_trigger_clock_sync_routing.sv */
// Purpose: Self-checking bench for the trigger, clock and sync router
// Assumes: Register port driven just after rising edges
// Notes:   Rising edges and high cycles of outputs are counted per window
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
    $display("unexpected %s exp %0h got %0h", nm, e, g); end end
module tb_trigger_clock_sync_routing
    import tcsr_pkg::*;
;
    logic        i_clk, i_resetn, i_wr, i_rd, i_osc, i_timer_evt, i_acq_done, loop_en, run;
    logic        o_adc_clk, o_adc_sync, o_trigger, o_acquiring;
    logic [2:0]  run_line;
    logic [7:0]  i_addr, bus_lvl, o_trig_bus, o_trig_bus_oe, drv, drv_en;
    logic [10:0] w_q;
    logic [15:0] i_dio;
    logic [31:0] i_wdata, o_rdata, q;
    logic [47:0] i_min_trip, i_max_trip;
    logic [7:0]  ra[7] = '{A_DIR, A_SCOPE, A_CLK, A_SYNC, A_TRIG, A_CMD, 8'h30};
    logic [31:0] rv[7] = '{32'h0, 32'hff, 32'h880, 32'h880, 32'h8880, 32'h0, 32'h0};
    int          n_mismatch, samples_checked;
    int          cnt[22], base[22];
    wire  [10:0] w = {o_trigger, o_adc_sync, o_adc_clk, o_trig_bus};
    tcsr_top i_tcsr_top (.i_clk, .i_resetn, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
        .i_trig_bus(bus_lvl), .o_trig_bus, .o_trig_bus_oe, .i_osc, .i_dio, .i_timer_evt, .i_min_trip,
        .i_max_trip, .i_acq_done, .o_adc_clk, .o_adc_sync, .o_trigger, .o_acquiring);
    tcsr_bus_partner i_tcsr_bus_partner (.i_dev_drive(o_trig_bus), .i_dev_oe(o_trig_bus_oe), .i_drv(drv),
        .i_drv_en(drv_en), .i_loop_en(loop_en), .i_run(run), .i_run_line(run_line), .o_level(bus_lvl));
    // Clock and free-running oscillator off the clock grid
    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end
    initial begin
        i_osc = 1'b0;
        #37;
        forever #400 i_osc = ~i_osc;
    end
    // Rising edges (0..10) and high cycles (11..21): lines, adc clk, sync, trigger
    always @(posedge i_clk) begin
        for (int k = 0; k < 11; k++) begin
            cnt[k] += int'(w[k] && !w_q[k]);
            cnt[k+11] += int'(w[k]);
        end
        w_q = w;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge i_clk);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 q = o_rdata;
    endtask
    task automatic hold(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task automatic mark;
        hold(1);
        base = cnt;
    endtask
    function automatic int df(input int k);
        return cnt[k] - base[k];
    endfunction
    task automatic win;
        hold(8);
        mark();
        hold(64);
    endtask
    task automatic done;
        i_acq_done <= 1'b1;
        @(posedge i_clk);
        i_acq_done <= 1'b0;
        hold(2);
        `CHK("acquiring", 1'b0, o_acquiring)
    endtask
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Watchdog
    initial begin
        #1_000_000;
        n_mismatch++;
        test_done();
    end
    initial begin
        {i_resetn, i_wr, i_rd, i_timer_evt, i_acq_done, loop_en, run} = 7'h00;
        {i_addr, drv, drv_en, run_line, w_q} = 38'h0;
        {i_dio, i_wdata, i_min_trip, i_max_trip} = 144'h0;
        repeat (4) @(posedge i_clk);
        i_resetn <= 1'b1;
        foreach (ra[k]) begin
            rd(ra[k]);
            `CHK("reset value", rv[k], q)
        end
        // Standalone, lines internal only
        wr(A_DIR, 32'hff);
        wr(A_SCOPE, 32'h00);
        win();
        `CHK("osc edges", 8'h08, df(8))
        `CHK("bus edges", 8'h00, df(0)+df(1)+df(2)+df(3)+df(4)+df(5)+df(6)+df(7))
        `CHK("oe internal", 8'h00, o_trig_bus_oe)
        // Out on line 0, back on line 4 via hub
        wr(A_DIR, 32'h01);
        wr(A_SCOPE, 32'hff);
        loop_en <= 1'b1;
        wr(A_CLK, 32'h400);
        win();
        `CHK("line0 edges", 8'h08, df(0))
        `CHK("return edges", 8'h08, df(8))
        `CHK("oe line0", 8'h01, o_trig_bus_oe)
        loop_en <= 1'b0;
        win();
        `CHK("no return", 8'h00, df(8))
        // Slave clock from remote on line 5, then none
        wr(A_DIR, 32'h00);
        wr(A_CLK, 32'h581);
        run_line <= 3'h5;
        run <= 1'b1;
        win();
        `CHK("slave edges", 8'h08, df(8))
        run <= 1'b0;
        wr(A_CLK, 32'h881);
        win();
        `CHK("slave none", 8'h00, df(8))
        wr(A_CLK, 32'h880);
        // Sync master on line 1
        wr(A_DIR, 32'h02);
        wr(A_SYNC, 32'h110);
        mark();
        wr(A_CMD, 32'h1);
        hold(12);
        `CHK("sync line edges", 8'h01, df(1))
        `CHK("sync line width", PULSE_CYC, df(12))
        `CHK("adc sync", 8'h01, df(9))
        // Sync slave on line 6
        wr(A_DIR, 32'h00);
        wr(A_SYNC, 32'h681);
        mark();
        wr(A_CMD, 32'h1);
        hold(12);
        `CHK("slave soft sync", 8'h00, df(9))
        drv_en <= 8'h40;
        drv <= 8'h40;
        hold(6);
        drv <= 8'h00;
        hold(6);
        `CHK("slave sync", 8'h01, df(9))
        wr(A_SYNC, 32'h880);
        // Immediate start
        mark();
        wr(A_CMD, 32'h4);
        hold(1);
        `CHK("imm trigger", 8'h01, df(10))
        `CHK("imm acq", 1'b1, o_acquiring)
        done();
        // Edge trigger on line 3, both polarities
        drv_en <= 8'h88;
        for (int f = 0; f < 2; f++) begin
            wr(A_TRIG, 32'h8831 | (f << FALL_B));
            mark();
            wr(A_CMD, 32'h4);
            rd(A_STAT);
            `CHK("waiting", 1'b1, q[WAIT_B])
            drv[3] <= 1'b1;
            hold(6);
            `CHK("rise trig", 8'(f == 0), df(10))
            drv[3] <= 1'b0;
            hold(6);
            `CHK("edge trig", 8'h01, df(10))
            done();
        end
        // Pattern of line 7 and dio 0, out and in on line 2
        wr(A_DIR, 32'h04);
        wr(A_TRIG, 32'h2282);
        wr(A_PLXI, 32'h8080);
        wr(A_PDIO, 32'h0001_0001);
        mark();
        wr(A_CMD, 32'h4);
        i_dio[0] <= 1'b1;
        hold(6);
        `CHK("half pattern", 8'h00, df(10))
        drv[7] <= 1'b1;
        hold(10);
        `CHK("pattern trig", 8'h01, df(10))
        `CHK("pattern out", PULSE_CYC, df(13))
        done();
        wr(A_PLXI, 32'h0);
        wr(A_PDIO, 32'h0);
        // Pattern from timer, then from software trigger
        for (int e = 0; e < 2; e++) begin
            wr(A_PMISC, 32'h1 << e);
            mark();
            wr(A_CMD, 32'h4);
            if (e == 0) i_timer_evt <= 1'b1;
            else wr(A_CMD, 32'h2);
            @(posedge i_clk);
            i_timer_evt <= 1'b0;
            hold(10);
            `CHK("misc pattern", 8'h01, df(10))
            done();
        end
        // Limit trips onto line 7
        wr(A_DIR, 32'h80);
        wr(A_LIMR, 32'h80);
        i_min_trip[10] <= 1'b1;
        hold(3);
        `CHK("limit line", 1'b1, o_trig_bus[7])
        i_min_trip <= 48'h0;
        i_max_trip[47] <= 1'b1;
        rd(A_LIMS);
        `CHK("limit status", 32'h3, q)
        i_max_trip <= 48'h0;
        wr(A_LIMS, 32'h3);
        rd(A_LIMS);
        `CHK("limit clear", 32'h0, q)
        test_done();
    end
endmodule // tb_trigger_clock_sync_routing
`default_nettype wire

/* File: test/tcsr_assertions.sv */
// Purpose: Port-level checks for the trigger, clock and sync router
// Assumes: Only tcsr_top ports are seen; routing registers shadowed from writes
// Notes:   Bound into every tcsr_top instance
`timescale 1ns/1ps
`default_nettype none
module tcsr_assertions
    import tcsr_pkg::*;
#(
    parameter int DIO_W = 16,
    parameter int CH    = 48
) (
    // Clock, reset and register port
    input wire logic              i_clk,
    input wire logic              i_resetn,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [31:0]       i_wdata,
    input wire logic              i_wr,
    input wire logic              i_rd,
    input wire logic [31:0]       o_rdata,
    // Bus, oscillator and limits
    input wire logic [LINES-1:0]  o_trig_bus,
    input wire logic [LINES-1:0]  o_trig_bus_oe,
    input wire logic              i_osc,
    input wire logic [CH-1:0]     i_min_trip,
    input wire logic [CH-1:0]     i_max_trip,
    input wire logic              i_acq_done,
    // ADC side
    input wire logic              o_adc_clk,
    input wire logic              o_adc_sync,
    input wire logic              o_trigger,
    input wire logic              o_acquiring
);
    logic [7:0]  dir_ff, scope_ff, limr_ff;
    logic [11:0] clk_ff;
    logic [2:0]  quiet_ff;
    // Shadow routing registers; count cycles since the clock setup changed
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            dir_ff   <= DIR_RST;
            scope_ff <= SCOPE_RST;
            limr_ff  <= 8'h00;
            clk_ff   <= 12'h880;
            quiet_ff <= 3'h0;
        end else begin
            if (i_wr && i_addr == A_DIR) dir_ff <= i_wdata[7:0];
            if (i_wr && i_addr == A_SCOPE) scope_ff <= i_wdata[7:0];
            if (i_wr && i_addr == A_LIMR) limr_ff <= i_wdata[7:0];
            if (i_wr && i_addr == A_CLK) {clk_ff, quiet_ff} <= {i_wdata[11:0], 3'h0};
            else if (quiet_ff != 3'h7) quiet_ff <= quiet_ff + 3'h1;
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    a_oe_dir_scope: assert property (!$past(i_wr) |-> o_trig_bus_oe == (dir_ff & scope_ff))
        else $error("oe differs from dir and scope");
    a_adc_osc_path: assert property ((!clk_ff[0] && clk_ff[7] && clk_ff[11] && quiet_ff >= 3'h4)
        |-> o_adc_clk == $past(i_osc, 3)) else $error("adc clock not from oscillator");
    a_slave_no_line: assert property ((clk_ff[0] && clk_ff[11] && quiet_ff >= 3'h2) |-> !o_adc_clk)
        else $error("slave with no line has clock");
    a_trig_one_cycle: assert property (o_trigger |=> !o_trigger)
        else $error("trigger too long");
    a_acq_with_trig: assert property ($rose(o_acquiring) |-> o_trigger)
        else $error("acquiring without trigger");
    a_done_ends_acq: assert property (o_acquiring && i_acq_done && !o_trigger |=> !o_acquiring)
        else $error("acquiring after done");
    a_sync_one_cycle: assert property (o_adc_sync |=> !o_adc_sync)
        else $error("sync too long");
    a_limit_drive: assert property (($past(|{i_min_trip, i_max_trip}) && !$past(i_wr))
        |-> (o_trig_bus & limr_ff) == limr_ff) else $error("limit line not driven");
    a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
        else $error("read data out of cycle");
endmodule // tcsr_assertions
bind tcsr_top tcsr_assertions #(.DIO_W(DIO_W), .CH(CH)) i_tcsr_assertions (.i_clk, .i_resetn, .i_addr,
    .i_wdata, .i_wr, .i_rd, .o_rdata, .o_trig_bus, .o_trig_bus_oe, .i_osc, .i_min_trip, .i_max_trip,
    .i_acq_done, .o_adc_clk, .o_adc_sync, .o_trigger, .o_acquiring);
`default_nettype wire

/* File: test/tcsr_bus_partner.sv */
// Purpose: Far side of the trigger bus: remote instruments and a hub
// Assumes: Released lines rest at the pull level
// Notes:   Hub loops line 0 back onto line 4; remote clock runs only in frames
`timescale 1ns/1ps
`default_nettype none
module tcsr_bus_partner
    import tcsr_pkg::*;
#(
    parameter logic PULL = 1'b0
) (
    // Device drive
    input  wire logic [LINES-1:0] i_dev_drive,
    input  wire logic [LINES-1:0] i_dev_oe,
    // Remote instruments and hub
    input  wire logic [LINES-1:0] i_drv,
    input  wire logic [LINES-1:0] i_drv_en,
    input  wire logic             i_loop_en,
    input  wire logic             i_run,
    input  wire logic [2:0]       i_run_line,
    // Resolved line levels
    output logic      [LINES-1:0] o_level
);
    logic lclk;
    // Remote master clock, still between frames
    initial begin
        lclk = 1'b0;
        forever #400 lclk = i_run ? ~lclk : 1'b0;
    end
    // Wire level from all drivers
    always_comb begin
        o_level = {LINES{PULL}};
        for (int k = 0; k < LINES; k++) begin
            if (i_dev_oe[k]) o_level[k] = i_dev_drive[k];
            else if (i_run && i_run_line == 3'(k)) o_level[k] = lclk;
            else if (i_drv_en[k]) o_level[k] = i_drv[k];
        end
        if (i_loop_en && !i_dev_oe[4]) o_level[4] = o_level[0];
    end
endmodule // tcsr_bus_partner
`default_nettype wire
